// *** inc/pss_regs.svh ***
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// Register word offsets (byte addresses, one word each)
`define PSS_OFS_MAX_FREQ    8'h00
`define PSS_OFS_DIG_FREQ    8'h04
`define PSS_OFS_RUN_SRC     8'h08
`define PSS_OFS_MODE        8'h0c
`define PSS_OFS_CYC_LIMIT   8'h10
`define PSS_OFS_MEM_OPTS    8'h14
`define PSS_OFS_TIME_UNIT   8'h18
`define PSS_OFS_STATUS      8'h1c
`define PSS_OFS_PROGRESS    8'h20
`define PSS_OFS_ELAPSED     8'h24
// Bases of the per-segment arrays, word k at base + 4*k, k = 1..15
`define PSS_BASE_SPEED      8'h40
`define PSS_BASE_SEG_TIME   8'h80
`define PSS_BASE_SEG_CFG    8'hc0
// Field positions
`define PSS_MEM_STOP_BIT    0
`define PSS_MEM_PWR_BIT     4
`define PSS_CFG_DIR_BIT     0
`define PSS_CFG_RAMP_LSB    4
// Reset values
`define PSS_RST_MAX_FREQ    16'h1388
`define PSS_RST_CYC_LIMIT   14'h0001
`define PSS_RST_SEG_TIME    16'h0032
`define PSS_RST_SPEED_STEP  16'h01f4
`define PSS_RST_SPEED_CAP   16'h1388
// Limits
`define PSS_CYC_MAX         14'h2710
`define PSS_SEG_TIME_MAX    16'hea60
`define PSS_MIN_PER_UNIT    6'h3c
// Timing: base tick of 0.1 s at 10 MHz
`define PSS_CLK_HZ          10000000
`define PSS_TICK_MS         100
`define PSS_TICK_CYCLES     ((`PSS_CLK_HZ / 1000) * `PSS_TICK_MS)
`endif

// *** inc/pss_pkg.sv ***
package pss_pkg;
  // Sequencer state
  typedef enum logic [1:0] {
    PSS_IDLE = 2'b00,
    PSS_RUN  = 2'b01,
    PSS_HOLD = 2'b10,
    PSS_DONE = 2'b11
  } pss_state_t;
  // Run modes of the sequencer
  typedef enum logic [1:0] {
    PSS_ONCE     = 2'b00,
    PSS_LIMITED  = 2'b01,
    PSS_LIM_HOLD = 2'b10,
    PSS_ENDLESS  = 2'b11
  } pss_mode_t;
  // Run command sources
  typedef enum logic [1:0] {
    PSS_SRC_KEY  = 2'b00,
    PSS_SRC_TERM = 2'b01,
    PSS_SRC_COMM = 2'b10
  } pss_src_t;
endpackage : pss_pkg

// *** core/pss_tick.sv ***
`timescale 1ns/10ps
// Free running divider giving a one-cycle enable every DIV clocks
module pss_tick #(
  parameter int DIV = 1000000
) (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic SRST,
  // Tick out
  output logic      tick
);
  logic [31:0] cnt_r;   // Cycles since last tick

  ////////////////////////////////////////////////////////////////
  // Count up the period
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cnt_r <= 32'h0;
      tick  <= 1'b0;
    end
    else if (cnt_r == 32'(DIV - 1))
    begin
      cnt_r <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule : pss_tick

// *** core/pss_seg_scan.sv ***
`timescale 1ns/10ps
// Finds first, last and next enabled segment from a mask (bit k = segment k)
module pss_seg_scan #(
  parameter int N = 15
) (
  // Inputs
  input  wire logic [N:1] en_mask,
  input  wire logic [3:0] cur,
  // Results, zero when nothing is enabled
  output logic [3:0]      first_seg,
  output logic [3:0]      last_seg,
  output logic [3:0]      next_seg
);
  ////////////////////////////////////////////////////////////////
  // Priority scans
  always_comb
  begin
    first_seg = 4'h0;
    last_seg  = 4'h0;
    next_seg  = 4'h0;
    for (int k = 1; k <= N; k++)
    begin
      if (en_mask[k])
        last_seg = 4'(k);
    end
    for (int k = N; k >= 1; k--)
    begin
      if (en_mask[k])
        first_seg = 4'(k);
    end
    for (int k = N; k >= 1; k--)
    begin
      if (en_mask[k] && (4'(k) > cur))
        next_seg = 4'(k);
    end
  end
endmodule : pss_seg_scan

// *** core/pss_top.sv ***
`timescale 1ns/10ps
`include "pss_regs.svh"
// Functional notes
// - Fifteen preset speeds, clamped to maximum frequency
// - Terminal code picks digital setpoint or preset
// - Run/stop taken from chosen command source
// - Ramp terminal selects ramp set in presets
// - Preset direction from forward/reverse with run
// - Mode 0 runs once, then stops
// - Mode 1 repeats, stops after cycle limit
// - Mode 2 repeats, then holds last speed
// - Mode 3 cycles until stop command
// - Cycle limit 1 to 10000, default 1
// - Last segment: highest with nonzero time
// - Zero-time segments are skipped
// - Stop memory: resume or restart on run
// - Power-loss memory: resume or restart after power
// - Segment time in seconds or minutes, tenths
// - Segment direction and ramp set per segment
// - Memory keeps cycles, segment and elapsed time
module pss_top
  import pss_pkg::*;
#(
  parameter int NSEG        = 15,
  parameter int TICK_CYCLES = `PSS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  // Terminals and commands
  input  wire logic [3:0]  SPD_SEL,
  input  wire logic        KEY_RUN,
  input  wire logic        TERM_RUN,
  input  wire logic        COMM_RUN,
  input  wire logic        TERM_REV,
  input  wire logic        RAMP_TERM_EN,
  input  wire logic [1:0]  RAMP_TERM,
  input  wire logic        SEQ_ENABLE,
  input  wire logic        POWER_RESTORED,
  // Drive command
  output logic [15:0]      FREQ_CMD,
  output logic             DIR_REV,
  output logic [1:0]       RAMP_SET,
  output logic             RUNNING,
  output logic             SEQ_DONE
);
  ////////////////////////////////////////////////////////////////
  // Configuration storage
  logic [15:0] max_freq_r;                // Hundredths of Hz
  logic [15:0] dig_freq_r;                // Digital setpoint
  pss_src_t    run_src_r;                 // Command source
  pss_mode_t   mode_r;                    // Sequencer mode
  logic [13:0] cyc_limit_r;               // Cycle limit
  logic        mem_stop_r;                // Stop memory digit
  logic        mem_pwr_r;                 // Power-loss memory digit
  logic        unit_min_r;                // Time unit, 1 = minutes
  logic [15:0] speed_r    [1:NSEG];       // Preset speeds
  logic [15:0] seg_time_r [1:NSEG];       // Segment times, tenths
  logic        seg_rev_r  [1:NSEG];       // Segment direction
  logic [1:0]  seg_ramp_r [1:NSEG];       // Segment ramp set
  // Sequencer progress
  pss_state_t  state_r;                   // Sequencer state
  logic [3:0]  seg_r;                     // Current segment, 0 = none
  logic [13:0] cyc_done_r;                // Completed cycles
  logic [15:0] elapsed_r;                 // Tenths of unit in segment
  logic [5:0]  min_pre_r;                 // Tick prescaler for minutes
  logic        run_d_r;                   // Run level last cycle
  // Helpers
  logic        tick;                      // 0.1 s enable
  logic        unit_tick;                 // One tenth of a time unit
  logic        run_now;                   // Selected run level
  logic        run_rise;                  // Start edge
  logic        run_fall;                  // Stop edge
  logic [NSEG:1] en_mask;                 // Segments with time
  logic [3:0]  first_seg;                 // First enabled segment
  logic [3:0]  last_seg;                  // Last enabled segment
  logic [3:0]  next_seg;                  // Next enabled segment
  logic        seg_expire;                // Current segment finished
  logic [3:0]  idx;                       // Array index of address

  ////////////////////////////////////////////////////////////////
  // Submodules
  pss_tick #(.DIV(TICK_CYCLES)) u_tick (
    .CLOCK (CLOCK),
    .SRST  (SRST),
    .tick  (tick)
  );

  pss_seg_scan #(.N(NSEG)) u_scan (
    .en_mask   (en_mask),
    .cur       (seg_r),
    .first_seg (first_seg),
    .last_seg  (last_seg),
    .next_seg  (next_seg)
  );

  ////////////////////////////////////////////////////////////////
  // Combinational helpers
  always_comb
  begin
    for (int k = 1; k <= NSEG; k++)
      // enabled only when time is nonzero
      en_mask[k] = (seg_time_r[k] != 16'h0);
  end

  assign idx = ADDR[5:2];

  // run level from the configured source
  always_comb
  begin
    case (run_src_r)
      PSS_SRC_TERM: run_now = TERM_RUN;
      PSS_SRC_COMM: run_now = COMM_RUN;
      default:      run_now = KEY_RUN;
    endcase
  end

  assign run_rise = run_now & ~run_d_r;
  assign run_fall = ~run_now & run_d_r;
  // minutes stretch each tenth by sixty base ticks
  assign unit_tick = tick & (~unit_min_r | (min_pre_r == `PSS_MIN_PER_UNIT - 6'h1));
  assign seg_expire = (elapsed_r >= seg_time_r[seg_r == 4'h0 ? 4'h1 : seg_r]);

  ////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      max_freq_r  <= `PSS_RST_MAX_FREQ;
      dig_freq_r  <= 16'h0;
      run_src_r   <= PSS_SRC_KEY;
      mode_r      <= PSS_ONCE;
      cyc_limit_r <= `PSS_RST_CYC_LIMIT;
      mem_stop_r  <= 1'b0;
      mem_pwr_r   <= 1'b0;
      unit_min_r  <= 1'b0;
      for (int k = 1; k <= NSEG; k++)
      begin
        // Defaults step by 5 Hz up to a cap
        speed_r[k]    <= (16'(k - 1) * `PSS_RST_SPEED_STEP > `PSS_RST_SPEED_CAP) ? `PSS_RST_SPEED_CAP
                         : 16'(k - 1) * `PSS_RST_SPEED_STEP;
        seg_time_r[k] <= `PSS_RST_SEG_TIME;
        seg_rev_r[k]  <= 1'b0;
        seg_ramp_r[k] <= 2'h0;
      end
    end
    else if (WR)
    begin
      if (ADDR == `PSS_OFS_MAX_FREQ)
        max_freq_r <= WDATA[15:0];
      else if (ADDR == `PSS_OFS_DIG_FREQ)
        dig_freq_r <= WDATA[15:0];
      else if (ADDR == `PSS_OFS_RUN_SRC)
        run_src_r <= pss_src_t'(WDATA[1:0]);
      else if (ADDR == `PSS_OFS_MODE)
        mode_r <= pss_mode_t'(WDATA[1:0]);
      else if (ADDR == `PSS_OFS_CYC_LIMIT)
      begin
        if (WDATA[31:0] != 32'h0 && WDATA[31:0] <= 32'(`PSS_CYC_MAX))
          cyc_limit_r <= WDATA[13:0];
      end
      else if (ADDR == `PSS_OFS_MEM_OPTS)
      begin
        mem_stop_r <= WDATA[`PSS_MEM_STOP_BIT];
        mem_pwr_r  <= WDATA[`PSS_MEM_PWR_BIT];
      end
      else if (ADDR == `PSS_OFS_TIME_UNIT)
        unit_min_r <= WDATA[0];
      else if (ADDR[7:6] == 2'h1 && idx != 4'h0)
        speed_r[idx] <= WDATA[15:0];
      else if (ADDR[7:6] == 2'h2 && idx != 4'h0)
      begin
        if (WDATA[31:0] <= 32'(`PSS_SEG_TIME_MAX))
          seg_time_r[idx] <= WDATA[15:0];
      end
      else if (ADDR[7:6] == 2'h3 && idx != 4'h0)
      begin
        seg_rev_r[idx]  <= WDATA[`PSS_CFG_DIR_BIT];
        seg_ramp_r[idx] <= WDATA[`PSS_CFG_RAMP_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register reads, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      RDATA <= 32'h0;
    else if (!RD)
      RDATA <= 32'h0;
    else if (ADDR == `PSS_OFS_MAX_FREQ)
      RDATA <= {16'h0, max_freq_r};
    else if (ADDR == `PSS_OFS_DIG_FREQ)
      RDATA <= {16'h0, dig_freq_r};
    else if (ADDR == `PSS_OFS_RUN_SRC)
      RDATA <= {30'h0, run_src_r};
    else if (ADDR == `PSS_OFS_MODE)
      RDATA <= {30'h0, mode_r};
    else if (ADDR == `PSS_OFS_CYC_LIMIT)
      RDATA <= {18'h0, cyc_limit_r};
    else if (ADDR == `PSS_OFS_MEM_OPTS)
      RDATA <= {27'h0, mem_pwr_r, 3'h0, mem_stop_r};
    else if (ADDR == `PSS_OFS_TIME_UNIT)
      RDATA <= {31'h0, unit_min_r};
    else if (ADDR == `PSS_OFS_STATUS)
      RDATA <= {22'h0, last_seg, 4'h0, state_r};
    else if (ADDR == `PSS_OFS_PROGRESS)
      RDATA <= {12'h0, seg_r, 2'h0, cyc_done_r};
    else if (ADDR == `PSS_OFS_ELAPSED)
      RDATA <= {16'h0, elapsed_r};
    else if (ADDR[7:6] == 2'h1 && idx != 4'h0)
      RDATA <= {16'h0, speed_r[idx]};
    else if (ADDR[7:6] == 2'h2 && idx != 4'h0)
      RDATA <= {16'h0, seg_time_r[idx]};
    else if (ADDR[7:6] == 2'h3 && idx != 4'h0)
      RDATA <= {26'h0, seg_ramp_r[idx], 3'h0, seg_rev_r[idx]};
    else
      RDATA <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////
  // Run edge tracking
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
      run_d_r <= 1'b0;
    else
      run_d_r <= run_now;
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer; progress counters are the memory, kept or cleared
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state_r    <= PSS_IDLE;
      seg_r      <= 4'h0;
      cyc_done_r <= 14'h0;
      elapsed_r  <= 16'h0;
      min_pre_r  <= 6'h0;
    end
    // power return restarts unless memory is on
    else if (POWER_RESTORED)
    begin
      state_r <= PSS_IDLE;
      if (!mem_pwr_r)
      begin
        seg_r      <= 4'h0;
        cyc_done_r <= 14'h0;
        elapsed_r  <= 16'h0;
        min_pre_r  <= 6'h0;
      end
    end
    else if (!SEQ_ENABLE || run_fall)
    begin
      state_r <= PSS_IDLE;
      // without stop memory progress is dropped
      // with memory all three counters stay on a stop; a disable clears them
      if (!mem_stop_r || !SEQ_ENABLE)
      begin
        seg_r      <= 4'h0;
        cyc_done_r <= 14'h0;
        elapsed_r  <= 16'h0;
        min_pre_r  <= 6'h0;
      end
    end
    else
    begin
      case (state_r)
        PSS_IDLE:
        begin
          if (run_rise)
          begin
            if (first_seg == 4'h0)
              state_r <= PSS_DONE;
            else
            begin
              state_r <= PSS_RUN;
              // resume a remembered segment if still enabled
              if (seg_r == 4'h0 || !en_mask[seg_r])
              begin
                seg_r     <= first_seg;
                elapsed_r <= 16'h0;
              end
            end
          end
        end
        PSS_RUN:
        begin
          if (seg_expire)
          begin
            elapsed_r <= 16'h0;
            min_pre_r <= 6'h0;
            if (seg_r >= last_seg)
            begin
              if (cyc_done_r != `PSS_CYC_MAX)
                cyc_done_r <= cyc_done_r + 14'h1;
              case (mode_r)
                PSS_ONCE:
                  state_r <= PSS_DONE;
                PSS_LIMITED:
                begin
                  if (cyc_done_r + 14'h1 >= cyc_limit_r)
                    state_r <= PSS_DONE;
                  else
                    seg_r <= first_seg;
                end
                // hold last speed at the limit
                PSS_LIM_HOLD:
                begin
                  if (cyc_done_r + 14'h1 >= cyc_limit_r)
                    state_r <= PSS_HOLD;
                  else
                    seg_r <= first_seg;
                end
                default:
                  seg_r <= first_seg;
              endcase
            end
            else
              seg_r <= next_seg;
          end
          else if (tick)
          begin
            min_pre_r <= (unit_tick || !unit_min_r) ? 6'h0 : min_pre_r + 6'h1;
            if (unit_tick)
              elapsed_r <= elapsed_r + 16'h1;
          end
        end
        // Hold and done leave only by a stop, disable or power return
        default:
          state_r <= state_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Drive command outputs
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      FREQ_CMD <= 16'h0;
      DIR_REV  <= 1'b0;
      RAMP_SET <= 2'h0;
      RUNNING  <= 1'b0;
      SEQ_DONE <= 1'b0;
    end
    else if (SEQ_ENABLE)
    begin
      RUNNING  <= (state_r == PSS_RUN) || (state_r == PSS_HOLD);
      SEQ_DONE <= (state_r == PSS_DONE);
      if (seg_r != 4'h0 && state_r != PSS_DONE && state_r != PSS_IDLE)
      begin
        // segment k uses preset k, clamped
        FREQ_CMD <= (speed_r[seg_r] > max_freq_r) ? max_freq_r : speed_r[seg_r];
        DIR_REV  <= seg_rev_r[seg_r];
        RAMP_SET <= seg_ramp_r[seg_r];
      end
      else
        FREQ_CMD <= 16'h0;
    end
    else
    begin
      RUNNING  <= run_now;
      SEQ_DONE <= 1'b0;
      // code zero is the digital setpoint
      if (SPD_SEL == 4'h0)
        FREQ_CMD <= (dig_freq_r > max_freq_r) ? max_freq_r : dig_freq_r;
      else
        FREQ_CMD <= (speed_r[SPD_SEL] > max_freq_r) ? max_freq_r : speed_r[SPD_SEL];
      DIR_REV  <= TERM_REV;
      RAMP_SET <= RAMP_TERM_EN ? RAMP_TERM : 2'h0;
    end
  end
endmodule : pss_top

// *** testbench/pss_top_properties.sv ***
`timescale 1ns/10ps
// Watches the drive command ports against the terminal and run inputs
module pss_chk
  import pss_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SRST,
  // Register strobe
  input wire logic        WR,
  // Terminals and commands
  input wire logic [3:0]  SPD_SEL,
  input wire logic        KEY_RUN,
  input wire logic        TERM_RUN,
  input wire logic        COMM_RUN,
  input wire logic        TERM_REV,
  input wire logic        RAMP_TERM_EN,
  input wire logic [1:0]  RAMP_TERM,
  input wire logic        SEQ_ENABLE,
  input wire logic        POWER_RESTORED,
  // Drive command
  input wire logic [15:0] FREQ_CMD,
  input wire logic        DIR_REV,
  input wire logic [1:0]  RAMP_SET,
  input wire logic        RUNNING,
  input wire logic        SEQ_DONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Every source asking to run, or none; the checker cannot see the selected source
  wire all_run = KEY_RUN && TERM_RUN && COMM_RUN;
  wire no_run  = !KEY_RUN && !TERM_RUN && !COMM_RUN;
  wire stay    = SEQ_ENABLE && all_run && !POWER_RESTORED;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_idle_low;
    SEQ_ENABLE ##1 SEQ_ENABLE && !RUNNING && !SEQ_DONE && no_run;
  endsequence
  sequence s_done_held;
    (SEQ_DONE && stay) [*2];
  endsequence
  property p_preset_stop;
    !SEQ_ENABLE && no_run |=> !RUNNING;
  endproperty
  property p_preset_dir;
    !SEQ_ENABLE |=> DIR_REV == $past(TERM_REV);
  endproperty
  property p_preset_ramp;
    !SEQ_ENABLE |=> RAMP_SET == ($past(RAMP_TERM_EN) ? $past(RAMP_TERM) : 2'h0);
  endproperty
  property p_preset_hold;
    !SEQ_ENABLE && $stable(SEQ_ENABLE) && $stable(SPD_SEL) && $stable({KEY_RUN, TERM_RUN, COMM_RUN})
      && !$past(WR) && !$past(SRST) |=> $stable(FREQ_CMD);
  endproperty
  property p_done_excl;
    SEQ_DONE |-> !RUNNING;
  endproperty
  property p_done_stay;
    s_done_held |=> SEQ_DONE;
  endproperty
  property p_seq_start;
    s_idle_low ##1 stay |=> ##1 (RUNNING || SEQ_DONE);
  endproperty
  property p_seq_stop;
    (SEQ_ENABLE && no_run) [*2] |=> !RUNNING;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_preset_stop: assert property (p_preset_stop)
    else $error("running with no run level");
  a_preset_dir: assert property (p_preset_dir)
    else $error("preset direction wrong");
  a_preset_ramp: assert property (p_preset_ramp)
    else $error("preset ramp set wrong");
  a_preset_hold: assert property (p_preset_hold)
    else $error("frequency moved with steady code");
  a_done_excl: assert property (p_done_excl)
    else $error("done while running");
  a_done_stay: assert property (p_done_stay)
    else $error("left done while run held");
  a_seq_start: assert property (p_seq_start)
    else $error("sequence did not start");
  a_seq_stop: assert property (p_seq_stop)
    else $error("sequence ignored stop");
endmodule : pss_chk
bind pss_top pss_chk pss_chk_i (.*);

// *** testbench/pss_terms.sv ***
`timescale 1ns/10ps
// Terminal strip: requested levels reach the drive one clock later
module pss_terms (
  // Clock
  input wire logic       clk,
  // Requests from the bench
  input wire logic [2:0] run_req,
  input wire logic       rev_req,
  input wire logic [1:0] ramp_req,
  input wire logic [3:0] sel_req,
  // Terminal levels
  output logic [2:0]     run_lvl = 3'h0,
  output logic           rev_lvl = 1'b0,
  output logic [1:0]     ramp_lvl = 2'h0,
  output logic [3:0]     sel_lvl = 4'h0
);
  // plain level terminals
  // Bit 3 of the code is terminal 4; no filtering, so each level follows its request one clock later
  always @(posedge clk)
  begin
    run_lvl  <= run_req;
    rev_lvl  <= rev_req;
    ramp_lvl <= ramp_req;
    sel_lvl  <= sel_req;
  end
endmodule : pss_terms

// *** testbench/pss_top_bench.sv ***
`timescale 1ns/10ps
`include "pss_regs.svh"
module pss_top_bench
  import pss_pkg::*;
;
  localparam logic [20:0] MALL = 21'h1fffff;
  localparam logic [20:0] MRUN = 21'h000002;
  localparam logic [20:0] MST  = 21'h000003;
  // Design ports
  logic        CLOCK = 1'b0;
  logic        SRST = 1'b1;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [31:0] RDATA;
  logic        SEQ_ENABLE = 1'b0;
  logic        POWER_RESTORED = 1'b0;
  logic [15:0] FREQ_CMD;
  logic        DIR_REV;
  logic [1:0]  RAMP_SET;
  logic        RUNNING;
  logic        SEQ_DONE;
  // Terminal requests and levels
  logic [2:0]  run_req = 3'h0;
  logic        rev_req = 1'b0;
  logic [1:0]  ramp_req = 2'h0;
  logic [3:0]  sel_req = 4'h0;
  logic [2:0]  run_lvl;
  logic        rev_lvl;
  logic [1:0]  ramp_lvl;
  logic [3:0]  sel_lvl;
  // Bench state
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          k;
  logic [31:0] rng = 32'h00018001;
  logic        mon_on = 1'b1;
  logic        rd_seen = 1'b0;
  logic [20:0] cur, prv = 21'h0, e_n, m_n;
  logic [15:0] r;
  logic [1:0]  rr;
  logic [20:0] eq[$], mq[$];
  logic [31:0] rq[$];
  // Short table of writes: limit and time bounds, unit toggle
  logic [7:0]  ta[7] = '{8'h10, 8'h10, 8'h10, 8'h84, 8'h84, 8'h18, 8'h18};
  logic [31:0] td[7] = '{32'h0, 32'h2711, 32'h2710, 32'hea61, 32'hea60, 32'h1, 32'h0};
  logic [31:0] tx[7] = '{32'h1, 32'h1, 32'h2710, 32'h32, 32'hea60, 32'h1, 32'h0};
  pss_terms pss_terms_i (.clk(CLOCK), .run_req(run_req), .rev_req(rev_req), .ramp_req(ramp_req),
    .sel_req(sel_req), .run_lvl(run_lvl), .rev_lvl(rev_lvl), .ramp_lvl(ramp_lvl), .sel_lvl(sel_lvl));
  // Short tick so one tenth of a second is ten clocks; ramp enable rides on reverse so both cases show
  pss_top #(.TICK_CYCLES(10)) pss_top_i (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SPD_SEL(sel_lvl), .KEY_RUN(run_lvl[0]), .TERM_RUN(run_lvl[1]),
    .COMM_RUN(run_lvl[2]), .TERM_REV(rev_lvl), .RAMP_TERM_EN(rev_lvl), .RAMP_TERM(ramp_lvl),
    .SEQ_ENABLE(SEQ_ENABLE), .POWER_RESTORED(POWER_RESTORED), .FREQ_CMD(FREQ_CMD), .DIR_REV(DIR_REV),
    .RAMP_SET(RAMP_SET), .RUNNING(RUNNING), .SEQ_DONE(SEQ_DONE));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz
  initial forever #50 CLOCK = ~CLOCK;
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  // Preset speed k after reset, already capped at the default maximum
  function automatic logic [15:0] sp(int n);
    return (n > 10) ? 16'h1388 : 16'((n - 1) * 500);
  endfunction : sp
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic step(int n);
    repeat (n) @(posedge CLOCK);
  endtask : step
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLOCK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] x);
    @(posedge CLOCK);
    ADDR <= a;
    RD   <= 1'b1;
    rq.push_back(x);
    @(posedge CLOCK);
    RD   <= 1'b0;
  endtask : rd
  // Note of the next drive command change, with the fields that matter
  task automatic note(logic [15:0] f, logic d, logic [1:0] rp, logic ru, logic dn, logic [20:0] m);
    eq.push_back({f, d, rp, ru, dn});
    mq.push_back(m);
  endtask : note
  task automatic drain(int n);
    repeat (n)
      if (eq.size() != 0)
        @(posedge CLOCK);
    chk("pending notes", 32'h0, 32'(eq.size()));
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  // Watcher: read data in its slot, every change of the drive command while mon_on is set
  always @(posedge CLOCK)
  begin
    if (rd_seen)
      chk("read data", rq.pop_front(), RDATA);
    rd_seen <= RD;
    cur = {FREQ_CMD, DIR_REV, RAMP_SET, RUNNING, SEQ_DONE};
    if (mon_on && !SRST && cur !== prv)
    begin
      if (eq.size() == 0)
        chk("unexpected change", 32'(prv), 32'(cur));
      else
      begin
        e_n = eq.pop_front();
        m_n = mq.pop_front();
        chk("drive command", 32'(e_n & m_n), 32'(cur & m_n));
      end
    end
    prv = cur;
  end
  // Hang guard
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    step(16);
    SRST <= 1'b0;
    rd(`PSS_OFS_MAX_FREQ, 32'h1388);
    rd(`PSS_OFS_MEM_OPTS, 32'h0);
    rd(8'h3c, 32'h0);
    rd(`PSS_BASE_SPEED, 32'h0);
    for (k = 1; k < 16; k++)
    begin
      rd(`PSS_BASE_SPEED + 8'(4 * k), 32'(sp(k)));
      rd(`PSS_BASE_SEG_TIME + 8'(4 * k), 32'h32);
      rd(`PSS_BASE_SEG_CFG + 8'(4 * k), 32'h0);
    end
    for (k = 0; k < 7; k++)
    begin
      wr(ta[k], td[k]);
      rd(ta[k], tx[k]);
    end
    wr(`PSS_BASE_SPEED + 8'h3c, 32'hffff);
    $display("test registers done");
    note(16'h0, 1'b0, 2'h0, 1'b1, 1'b0, MALL);
    run_req <= 3'h1;
    r = 16'(xs() % 5000 + 1);
    note(r, 1'b0, 2'h0, 1'b1, 1'b0, MALL);
    wr(`PSS_OFS_DIG_FREQ, 32'(r));
    step(4);
    // Every terminal code, direction toggling so each step shows
    for (k = 0; k < 16; k++)
    begin
      rr = 2'(xs());
      note(k == 0 ? r : sp(k), ~k[0], k[0] ? 2'h0 : rr, 1'b1, 1'b0, MALL);
      sel_req  <= 4'(k);
      rev_req  <= ~k[0];
      ramp_req <= rr;
      step(4);
    end
    for (k = 1; k < 3; k++)
    begin
      note(16'h0, 1'b0, 2'h0, 1'b0, 1'b0, MRUN);
      wr(`PSS_OFS_RUN_SRC, 32'(k));
      step(4);
      note(16'h0, 1'b0, 2'h0, 1'b1, 1'b0, MRUN);
      run_req <= 3'(1 << k);
      step(4);
    end
    note(16'h0, 1'b0, 2'h0, 1'b0, 1'b0, MRUN);
    run_req <= 3'h0;
    wr(`PSS_OFS_RUN_SRC, 32'(PSS_SRC_KEY));
    step(4);
    drain(10);
    $display("test preset done");
    // Segment 2 and 4..15 empty, so segment 3 is last
    mon_on <= 1'b0;
    SEQ_ENABLE <= 1'b1;
    wr(`PSS_BASE_SPEED + 8'h04, 32'h64);
    wr(`PSS_BASE_SEG_CFG + 8'h0c, 32'h21);
    for (k = 1; k < 16; k++)
      wr(`PSS_BASE_SEG_TIME + 8'(4 * k), k == 1 ? 32'h2 : (k == 3 ? 32'h1 : 32'h0));
    rd(`PSS_OFS_STATUS, 32'hc0);
    wr(`PSS_OFS_CYC_LIMIT, 32'h2);
    step(4);
    mon_on <= 1'b1;
    for (k = 0; k < 3; k++)
    begin
      wr(`PSS_OFS_MODE, 32'(k));
      repeat (k == 0 ? 1 : 2)
      begin
        note(16'h64, 1'b0, 2'h0, 1'b1, 1'b0, MALL);
        note(16'h3e8, 1'b1, 2'h2, 1'b1, 1'b0, MALL);
      end
      if (k != 2)
        note(16'h0, 1'b0, 2'h0, 1'b0, 1'b1, MST);
      run_req <= 3'h7;
      drain(400);
      step(60);
      rd(`PSS_OFS_STATUS, k == 2 ? 32'hc2 : 32'hc3);
      mon_on <= 1'b0;
      run_req <= 3'h0;
      step(6);
      mon_on <= 1'b1;
    end
    $display("test modes done");
    wr(`PSS_OFS_MODE, 32'(PSS_ENDLESS));
    wr(`PSS_OFS_MEM_OPTS, 32'h1);
    repeat (3)
    begin
      note(16'h64, 1'b0, 2'h0, 1'b1, 1'b0, MALL);
      note(16'h3e8, 1'b1, 2'h2, 1'b1, 1'b0, MALL);
    end
    run_req <= 3'h7;
    drain(600);
    mon_on <= 1'b0;
    run_req <= 3'h0;
    step(6);
    mon_on <= 1'b1;
    rd(`PSS_OFS_PROGRESS, 32'h30002);
    rd(`PSS_OFS_ELAPSED, 32'h0);
    note(16'h3e8, 1'b1, 2'h2, 1'b1, 1'b0, MALL);
    run_req <= 3'h7;
    drain(100);
    mon_on <= 1'b0;
    run_req <= 3'h0;
    step(6);
    POWER_RESTORED <= 1'b1;
    step(1);
    POWER_RESTORED <= 1'b0;
    step(4);
    mon_on <= 1'b1;
    rd(`PSS_OFS_PROGRESS, 32'h0);
    // Minutes: segment 1 now lasts about 1200 clocks, so nothing may move for a while
    wr(`PSS_OFS_TIME_UNIT, 32'h1);
    note(16'h64, 1'b0, 2'h0, 1'b1, 1'b0, MALL);
    run_req <= 3'h7;
    drain(100);
    step(150);
    note(16'h3e8, 1'b1, 2'h2, 1'b1, 1'b0, MALL);
    drain(1300);
    $display("test memory done");
    stop_test();
  end
endmodule : pss_top_bench
